// file: lct_params.svh
/*
  Constants of the configurable logic tile: register offsets, field
  positions, reset values and mode codes.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef LCT_PARAMS_SVH
`define LCT_PARAMS_SVH

`define LCT_LUT_BITS 16
`define LCT_LUT_AW 4
`define LCT_CFG_W 15
`define LCT_NUM_LUT 4

`define LCT_ADR_SLICE0 8'h00
`define LCT_ADR_SLICE1 8'h04
`define LCT_ADR_LUT0 8'h08
`define LCT_ADR_STRIDE 8'h04
`define LCT_ADR_STATUS 8'h18

`define LCT_F_MODE 2:0
`define LCT_F_LATCH 3
`define LCT_F_ASYNC 4
`define LCT_F_CLK_INV 5
`define LCT_F_CE_INV 6
`define LCT_F_INIT_INV 7
`define LCT_F_INVF_INV 8
`define LCT_F_BYP 9
`define LCT_F_INITV 11
`define LCT_F_MULT_AND 13
`define LCT_F_WIDE 14

`define LCT_ST_Q 3:0
`define LCT_ST_CO 5:4
`define LCT_ST_SWM 7:6

`define LCT_CFG_RST 15'h0000
`define LCT_LUT_RST 16'h0000

`define LCT_MODE_LOGIC 3'h0
`define LCT_MODE_RAM16X1 3'h1
`define LCT_MODE_RAM16X2 3'h2
`define LCT_MODE_RAM32X1 3'h3
`define LCT_MODE_RAM_DP 3'h4
`define LCT_MODE_SHIFT 3'h5

`endif

// file: lct_pkg.sv
/*
  Types shared by the logic tile modules.
  Assumes lct_params.svh is on the include path.
*/
`include "lct_params.svh"

package lct_pkg;
  typedef logic [`LCT_LUT_BITS-1:0] lct_lut_t;
  typedef logic [`LCT_LUT_AW-1:0] lct_addr_t;
  typedef logic [`LCT_CFG_W-1:0] lct_cfg_t;
  typedef enum logic [2:0] {
    LCT_LOGIC = `LCT_MODE_LOGIC,
    LCT_RAM16X1 = `LCT_MODE_RAM16X1,
    LCT_RAM16X2 = `LCT_MODE_RAM16X2,
    LCT_RAM32X1 = `LCT_MODE_RAM32X1,
    LCT_RAM_DP = `LCT_MODE_RAM_DP,
    LCT_SHIFT = `LCT_MODE_SHIFT
  } lct_mode_t;
  typedef enum logic [1:0] {
    LCT_WB_IDLE = 2'b01,
    LCT_WB_ACK = 2'b10
  } lct_wb_state_t;
endpackage

// file: lct_lut.sv
/*
  One 16-entry lookup table: function table, synchronous RAM or
  addressable shift register.
  Assumes write and shift strobes are one-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
`include "lct_params.svh"

module lct_lut (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire lct_pkg::lct_lut_t load_data_i,
  input wire logic wr_i,
  input wire lct_pkg::lct_addr_t wr_addr_i,
  input wire logic wr_data_i,
  input wire logic shift_i,
  input wire logic shift_data_i,
  input wire lct_pkg::lct_addr_t rd_addr_i,
  output logic rd_o,
  output lct_pkg::lct_lut_t content_o
);
  import lct_pkg::*;

  lct_lut_t mem_reg;
  lct_lut_t mem_next;

  // software load wins over a same-cycle fabric write or shift
  always_comb
  begin
    mem_next = mem_reg;
    if (load_i)
      mem_next = load_data_i;
    else if (shift_i)
      mem_next = {mem_reg[`LCT_LUT_BITS-2:0], shift_data_i};
    else if (wr_i)
      mem_next[wr_addr_i] = wr_data_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mem_reg <= `LCT_LUT_RST;
    else
      mem_reg <= mem_next;
  end

  assign rd_o = mem_reg[rd_addr_i];
  assign content_o = mem_reg;

  a_ram_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_i && !load_i && !shift_i) |=> mem_reg[$past(wr_addr_i)] == $past(wr_data_i))
    else $error("ram write not stored");
  a_shift_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (shift_i && !load_i) |=> mem_reg == {$past(mem_reg[`LCT_LUT_BITS-2:0]), $past(shift_data_i)})
    else $error("shift step wrong");
endmodule // lct_lut

// file: lct_store.sv
/*
  One storage element: flip-flop or latch with init and invert forcing.
  Assumes edge_i is a one-cycle pulse and level_i the active clock level.
*/
`timescale 1ns/1ps

module lct_store (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic latch_i,
  input wire logic async_i,
  input wire logic edge_i,
  input wire logic level_i,
  input wire logic ce_i,
  input wire logic init_i,
  input wire logic inv_i,
  input wire logic init_val_i,
  input wire logic d_i,
  output logic q_o
);
  import lct_pkg::*;

  logic q_reg;
  logic q_next;
  logic act;

  always_comb
  begin
    act = latch_i ? level_i : edge_i;
    q_next = q_reg;
    if (init_i && (async_i || act))
      q_next = init_val_i;
    else if (inv_i && (async_i || act))
      q_next = ~init_val_i;
    else if (ce_i && act)
      q_next = d_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      q_reg <= 1'b0;
    else
      q_reg <= q_next;
  end

  assign q_o = q_reg;

  a_ff_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!latch_i && !edge_i && !init_i && !inv_i) |=> $stable(q_reg))
    else $error("flip-flop changed without edge");
  a_ff_capture: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!latch_i && edge_i && ce_i && !init_i && !inv_i) |=> q_reg == $past(d_i))
    else $error("flip-flop missed capture");
  a_latch_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (latch_i && level_i && ce_i && !init_i && !inv_i) |=> q_reg == $past(d_i))
    else $error("latch not transparent");
  a_init_force: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (init_i && async_i) |=> q_reg == $past(init_val_i))
    else $error("init force failed");
  a_inv_force: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!init_i && inv_i && async_i) |=> q_reg != $past(init_val_i))
    else $error("invert force failed");
  a_sync_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (init_i && !async_i && !latch_i && !edge_i) |=> $stable(q_reg))
    else $error("sync force acted without edge");
endmodule // lct_store

// file: lct_tile.sv
/*
  Configurable logic tile: two slices of two logic cells, wide muxes,
  carry chains, feedthroughs and two tristate bus drivers, configured
  over a classic Wishbone slave.
  Assumes fabric inputs are synchronous to clk_i; slice clocks are
  sampled fabric signals; all outputs are registered one cycle.
*/
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "lct_params.svh"

module lct_tile (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] lut_in_i,
  input wire logic [3:0] byp_i,
  input wire logic [3:0] ft_i,
  input wire logic [3:0] wd_i,
  input wire logic [1:0] we_i,
  input wire logic [1:0] sclk_i,
  input wire logic [1:0] ce_i,
  input wire logic [1:0] init_force_i,
  input wire logic [1:0] invert_force_i,
  input wire logic [1:0] wsel_i,
  input wire logic tsel_i,
  input wire logic [1:0] carry_in_i,
  input wire logic [1:0] bus_d_i,
  input wire logic [1:0] bus_en_i,
  output logic [3:0] lut_o,
  output logic [3:0] q_o,
  output logic [3:0] sum_o,
  output logic [1:0] slice_wide_mux_o,
  output logic tile_wide_mux_o,
  output logic [1:0] carry_out_o,
  output logic [3:0] ft_o,
  output logic [1:0] bus_o,
  output logic [1:0] bus_oe_o
);
  import lct_pkg::*;

  function automatic logic [31:0] lct_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        old[8*b +: 8] = wd[8*b +: 8];
    end
    return old;
  endfunction

  lct_wb_state_t wb_state_reg;
  lct_wb_state_t wb_state_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [31:0] rd_word;
  logic [31:0] merged;
  logic wr_fire;
  lct_cfg_t cfg_reg [2];
  lct_cfg_t cfg_next [2];
  logic [`LCT_NUM_LUT-1:0] lut_load;
  lct_lut_t lut_wdata;
  lct_lut_t lut_content [`LCT_NUM_LUT];
  logic [1:0] sclk_prev_reg;
  logic [1:0] sclk_prev_next;

  wire [1:0] slice_pol;
  wire [3:0] f_vec;
  wire [3:0] sum_vec;
  wire [3:0] q_vec;
  wire [1:0] co_vec;
  wire [1:0] swm_vec;

  logic [3:0] lut_reg, lut_next;
  logic [3:0] q_reg, q_next;
  logic [3:0] sum_reg, sum_next;
  logic [1:0] swm_reg, swm_next;
  logic twm_reg, twm_next;
  logic [1:0] co_reg, co_next;
  logic [3:0] ft_reg, ft_next;
  logic [1:0] bus_reg, bus_next;
  logic [1:0] oe_reg, oe_next;

  // register read view, captured when the request is taken
  always_comb
  begin
    rd_word = '0;
    if (wb_adr_i == `LCT_ADR_SLICE0)
      rd_word = 32'(cfg_reg[0]);
    else if (wb_adr_i == `LCT_ADR_SLICE1)
      rd_word = 32'(cfg_reg[1]);
    else if (wb_adr_i == `LCT_ADR_STATUS)
    begin
      rd_word[`LCT_ST_Q] = q_reg;
      rd_word[`LCT_ST_CO] = co_reg;
      rd_word[`LCT_ST_SWM] = swm_reg;
    end
    for (int k = 0; k < `LCT_NUM_LUT; k++)
    begin
      if (wb_adr_i == 8'(`LCT_ADR_LUT0 + `LCT_ADR_STRIDE * k))
        rd_word = 32'(lut_content[k]);
    end
  end

  // bus slave: ack one cycle after the request, write at the ack edge
  always_comb
  begin
    wb_state_next = wb_state_reg;
    ack_next = 1'b0;
    dat_next = dat_reg;
    cfg_next = cfg_reg;
    lut_load = '0;
    lut_wdata = '0;
    merged = '0;
    sclk_prev_next = slice_pol;
    wr_fire = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i;
    case (wb_state_reg)
      LCT_WB_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          wb_state_next = LCT_WB_ACK;
          ack_next = 1'b1;
          dat_next = rd_word;
        end
      end
      LCT_WB_ACK:
        wb_state_next = LCT_WB_IDLE;
      default:
        wb_state_next = LCT_WB_IDLE;
    endcase
    if (wr_fire)
    begin
      if (wb_adr_i == `LCT_ADR_SLICE0 || wb_adr_i == `LCT_ADR_SLICE1)
      begin
        merged = lct_merge(32'(cfg_reg[wb_adr_i[2]]), wb_dat_i, wb_sel_i);
        cfg_next[wb_adr_i[2]] = merged[`LCT_CFG_W-1:0];
      end
      for (int k = 0; k < `LCT_NUM_LUT; k++)
      begin
        if (wb_adr_i == 8'(`LCT_ADR_LUT0 + `LCT_ADR_STRIDE * k))
        begin
          merged = lct_merge(32'(lut_content[k]), wb_dat_i, wb_sel_i);
          lut_wdata = merged[`LCT_LUT_BITS-1:0];
          lut_load[k] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wb_state_reg <= LCT_WB_IDLE;
      ack_reg <= 1'b0;
      dat_reg <= '0;
      cfg_reg[0] <= `LCT_CFG_RST;
      cfg_reg[1] <= `LCT_CFG_RST;
      sclk_prev_reg <= '0;
    end
    else
    begin
      wb_state_reg <= wb_state_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      cfg_reg <= cfg_next;
      sclk_prev_reg <= sclk_prev_next;
    end
  end

  for (genvar s = 0; s < 2; s++)
  begin : g_slice
    lct_cfg_t cfg;
    lct_mode_t mode;
    logic pol, edge_s, ce_s, ini, inv, wen;
    logic sh;
    logic [1:0] we, wd;
    lct_addr_t a0, a1;
    lct_addr_t wa [2];
    lct_addr_t ra [2];
    wire [2:0] ch;

    always_comb
    begin
      cfg = cfg_reg[s];
      mode = lct_mode_t'(cfg[`LCT_F_MODE]);
      pol = sclk_i[s] ^ cfg[`LCT_F_CLK_INV];
      ce_s = ce_i[s] ^ cfg[`LCT_F_CE_INV];
      ini = init_force_i[s] ^ cfg[`LCT_F_INIT_INV];
      inv = invert_force_i[s] ^ cfg[`LCT_F_INVF_INV];
      edge_s = pol & ~sclk_prev_reg[s];
      a0 = lut_in_i[8*s +: 4];
      a1 = lut_in_i[8*s+4 +: 4];
      wen = edge_s & we_i[s];
      sh = edge_s & ce_s & (mode == LCT_SHIFT);
      we = '0;
      wd = wd_i[2*s +: 2];
      wa[0] = a0;
      wa[1] = a1;
      ra[0] = a0;
      ra[1] = a1;
      case (mode)
        LCT_RAM16X1:
          we = {wen, wen};
        LCT_RAM16X2:
        begin
          we = {wen, wen};
          wa[1] = a0;
          ra[1] = a0;
        end
        LCT_RAM32X1:
        begin
          we = {wen & wsel_i[s], wen & ~wsel_i[s]};
          wd[1] = wd[0];
          wa[1] = a0;
          ra[1] = a0;
        end
        LCT_RAM_DP:
        begin
          we = {wen, wen};
          wd[1] = wd[0];
          wa[1] = a0;
        end
        default:
          we = '0;
      endcase
    end

    assign slice_pol[s] = pol;
    assign ch[0] = carry_in_i[s];
    assign co_vec[s] = ch[2];
    assign swm_vec[s] = wsel_i[s] ? f_vec[2*s+1] : f_vec[2*s];

    for (genvar c = 0; c < 2; c++)
    begin : g_cell
      localparam int N = 2 * s + c;
      logic g, d;

      lct_lut u_lut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .load_i(lut_load[N]),
        .load_data_i(lut_wdata),
        .wr_i(we[c]),
        .wr_addr_i(wa[c]),
        .wr_data_i(wd[c]),
        .shift_i(sh),
        .shift_data_i(wd_i[N]),
        .rd_addr_i(ra[c]),
        .rd_o(f_vec[N]),
        .content_o(lut_content[N])
      );

      always_comb
      begin
        g = cfg[`LCT_F_MULT_AND] ? (lut_in_i[4*N] & lut_in_i[4*N+1])
                                 : lut_in_i[4*N];
        if (cfg[`LCT_F_WIDE])
          g = 1'b0;
        d = cfg[`LCT_F_BYP + c] ? byp_i[N] : f_vec[N];
      end

      assign ch[c+1] = f_vec[N] ? ch[c] : g;
      assign sum_vec[N] = f_vec[N] ^ ch[c];

      lct_store u_store (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .latch_i(cfg[`LCT_F_LATCH]),
        .async_i(cfg[`LCT_F_ASYNC]),
        .edge_i(edge_s),
        .level_i(pol),
        .ce_i(ce_s),
        .init_i(ini),
        .inv_i(inv),
        .init_val_i(cfg[`LCT_F_INITV + c]),
        .d_i(d),
        .q_o(q_vec[N])
      );
    end
  end

  // all tile outputs leave through one register stage
  always_comb
  begin
    lut_next = f_vec;
    q_next = q_vec;
    sum_next = sum_vec;
    swm_next = swm_vec;
    twm_next = tsel_i ? swm_vec[1] : swm_vec[0];
    co_next = co_vec;
    ft_next = ft_i;
    bus_next = bus_d_i;
    oe_next = bus_en_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lut_reg <= '0;
      q_reg <= '0;
      sum_reg <= '0;
      swm_reg <= '0;
      twm_reg <= 1'b0;
      co_reg <= '0;
      ft_reg <= '0;
      bus_reg <= '0;
      oe_reg <= '0;
    end
    else
    begin
      lut_reg <= lut_next;
      q_reg <= q_next;
      sum_reg <= sum_next;
      swm_reg <= swm_next;
      twm_reg <= twm_next;
      co_reg <= co_next;
      ft_reg <= ft_next;
      bus_reg <= bus_next;
      oe_reg <= oe_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign lut_o = lut_reg;
  assign q_o = q_reg;
  assign sum_o = sum_reg;
  assign slice_wide_mux_o = swm_reg;
  assign tile_wide_mux_o = twm_reg;
  assign carry_out_o = co_reg;
  assign ft_o = ft_reg;
  assign bus_o = bus_reg;
  assign bus_oe_o = oe_reg;

  a_ack_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_slice_mux: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> slice_wide_mux_o[0] == ($past(wsel_i[0]) ? lut_o[1] : lut_o[0]))
    else $error("slice mux selected wrong table");
  a_tile_mux: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(resetn_i) |->
      tile_wide_mux_o == ($past(tsel_i) ? slice_wide_mux_o[1] : slice_wide_mux_o[0]))
    else $error("tile mux selected wrong slice");
  a_ft_path: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> ft_o == $past(ft_i))
    else $error("feedthrough mismatch");
  a_bus_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> (bus_oe_o == $past(bus_en_i)) && (bus_o == $past(bus_d_i)))
    else $error("bus driver mismatch");
  a_sum_xor: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> sum_o[0] == (lut_o[0] ^ $past(carry_in_i[0])))
    else $error("adder sum wrong");

  c_reg_write: cover property (@(posedge clk_i) disable iff (!resetn_i) wr_fire);
  c_shift: cover property (@(posedge clk_i) disable iff (!resetn_i) g_slice[0].sh);
  c_tile_mux: cover property (@(posedge clk_i) disable iff (!resetn_i)
    tsel_i && swm_vec[1]);
endmodule // lct_tile

// file: lct_fabric.sv
/*
  Far-side model of the routing fabric: makes slice clock pulses and
  resolves the two shared bus lines, which carry a pull-up.
  Assumes requests are driven just after the rising edge of clk_i.
*/
`timescale 1ns/1ps
module lct_fabric (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] req_i,
  input wire logic [1:0] hold_i,
  input wire logic [1:0] bus_d_i,
  input wire logic [1:0] bus_oe_i,
  output logic [1:0] sclk_o,
  output logic [1:0] bus_line_o
);
  logic [1:0] sclk_reg;
  logic [1:0] sclk_next;
  // a pulse is refused while the clock is high, so it rests low between edges
  always_comb
  begin
    sclk_next = hold_i | (req_i & ~sclk_reg);
  end
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sclk_reg <= 2'b00;
    else
      sclk_reg <= sclk_next;
  end
  assign sclk_o = sclk_reg;
  // a released line floats up to the pull-up level
  assign bus_line_o = ~bus_oe_i | bus_d_i;
endmodule // lct_fabric

// file: configurable_logic_tile_tb_top.sv
/*
  Self-checking bench of the logic tile: registers, tables, RAM, shift,
  storage, forcing, wide muxes, carry, feedthroughs and bus drivers.
  Assumes lct_fabric makes the slice clocks and the bus line levels.
*/
`timescale 1ns/1ps
module configurable_logic_tile_tb_top;
  import lct_pkg::*;
  logic clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tsel_i, tile_wide_mux_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, lut_o, q_o, sum_o, ft_o, byp_i, ft_i, wd_i, lv;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [15:0] lut_in_i;
  logic [1:0] we_i, sclk_i, ce_i, init_force_i, invert_force_i, wsel_i, carry_in_i;
  logic [1:0] bus_d_i, bus_en_i, slice_wide_mux_o, carry_out_o, bus_o, bus_oe_o;
  logic [1:0] req, hold, line;
  logic [2:0] s;
  int err_count, checks;
  // cell, table content, address, expected output
  logic [22:0] rows [8] = '{{2'd0, 16'h8000, 4'hf, 1'b1}, {2'd0, 16'h8000, 4'he, 1'b0},
    {2'd1, 16'hfffe, 4'h0, 1'b0}, {2'd1, 16'hfffe, 4'h5, 1'b1}, {2'd2, 16'h6996, 4'h7, 1'b1},
    {2'd2, 16'h6996, 4'h3, 1'b0}, {2'd3, 16'hcafe, 4'h0, 1'b0}, {2'd3, 16'hcafe, 4'hf, 1'b1}};
  // mode, wide select, write data, expected bit 3 of cell 1 and cell 0
  logic [7:0] rrow [5] = '{{LCT_RAM16X1, 1'b0, 2'b01, 2'b01}, {LCT_RAM16X2, 1'b0, 2'b10, 2'b10},
    {LCT_RAM32X1, 1'b1, 2'b01, 2'b10}, {LCT_RAM32X1, 1'b0, 2'b01, 2'b01},
    {LCT_RAM_DP, 1'b0, 2'b01, 2'b11}};
  // config, table content, table inputs, carry in, expected carry out
  logic [41:0] crow [6] = '{{16'h4000, 16'h8000, 8'hff, 2'b11}, {16'h4000, 16'h8000, 8'h7f, 2'b10},
    {16'h4000, 16'h8000, 8'hff, 2'b00}, {16'h2000, 16'h0000, 8'h10, 2'b00},
    {16'h2000, 16'h0000, 8'h30, 2'b01}, {16'h0000, 16'h0000, 8'h10, 2'b01}};
  logic [3:0] fbv [3] = '{4'h6, 4'h9, 4'h5};

  lct_tile u_dut (.*);
  lct_fabric u_fab (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req), .hold_i(hold),
    .bus_d_i(bus_o), .bus_oe_i(bus_oe_o), .sclk_o(sclk_i), .bus_line_o(line));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle: hold the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
      check("ack wait", 32'h0, 32'h1);
  endtask

  task automatic lw(input int c, input logic [31:0] d);
    wb(1'b1, 8'h08 + 8'(4 * c), d);
  endtask

  task automatic pulse(input int sl);
    @(posedge clk_i);
    req[sl] <= 1'b1;
    @(posedge clk_i);
    req[sl] <= 1'b0;
    tick(5);
  endtask

  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    {lut_in_i, byp_i, ft_i, wd_i, we_i, ce_i, init_force_i, invert_force_i} = '0;
    {wsel_i, tsel_i, carry_in_i, bus_d_i, bus_en_i, req, hold} = '0;
    err_count = 0;
    checks = 0;
    resetn_i = 1'b0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    check("q after reset", 32'(q_o), 32'h0);
    wb(1'b1, 8'h18, 32'hffffffff);
    wb(1'b1, 8'h1c, 32'hffffffff);
    for (int a = 0; a < 8; a++)
    begin
      wb(1'b0, 8'(4 * a), 32'h0);
      check("register reset", r, 32'h0);
    end
    wb(1'b1, 8'h04, 32'hffffffff);
    wb(1'b0, 8'h04, 32'h0);
    check("cfg width", r, 32'h00007fff);
    wb(1'b1, 8'h04, 32'h0);
    foreach (rows[i])
    begin
      lw(rows[i][22:21], 32'(rows[i][20:5]));
      lut_in_i[4 * rows[i][22:21] +: 4] <= rows[i][4:1];
      tick(3);
      check("table out", 32'(lut_o[rows[i][22:21]]), 32'(rows[i][0]));
      wb(1'b0, 8'h08 + 8'(4 * rows[i][22:21]), 32'h0);
      check("table word", r, 32'(rows[i][20:5]));
    end
    lv = 4'b1010;
    for (int k = 0; k < 8; k++)
    begin
      {tsel_i, wsel_i} <= 3'(k);
      tick(3);
      s[0] = k[0] ? lv[1] : lv[0];
      s[1] = k[1] ? lv[3] : lv[2];
      s[2] = k[2] ? s[1] : s[0];
      check("slice mux", 32'(slice_wide_mux_o), 32'(s[1:0]));
      check("tile mux", 32'(tile_wide_mux_o), 32'(s[2]));
    end
    {tsel_i, wsel_i} <= 3'h0;
    foreach (fbv[i])
    begin
      ft_i <= fbv[i];
      bus_d_i <= fbv[i][1:0];
      bus_en_i <= fbv[i][3:2];
      tick(3);
      check("feedthrough", 32'(ft_o), 32'(fbv[i]));
      check("bus enable", 32'(bus_oe_o), 32'(fbv[i][3:2]));
      check("bus line", 32'(line), {30'h0, ~fbv[i][3:2] | fbv[i][1:0]});
    end
    ce_i <= 2'b11;
    lw(0, 32'hffff);
    lw(1, 32'h0);
    pulse(0);
    check("ff load", 32'(q_o[1:0]), 32'h1);
    ce_i <= 2'b00;
    lw(0, 32'h0);
    pulse(0);
    check("ff hold", 32'(q_o[1:0]), 32'h1);
    ce_i <= 2'b11;
    pulse(0);
    check("ff capture", 32'(q_o[1:0]), 32'h0);
    wb(1'b1, 8'h00, 32'h40);
    ce_i <= 2'b00;
    lw(0, 32'hffff);
    pulse(0);
    check("ce inverted", 32'(q_o[1:0]), 32'h1);
    wb(1'b1, 8'h00, 32'h200);
    ce_i <= 2'b11;
    byp_i <= 4'h1;
    lw(0, 32'h0);
    pulse(0);
    check("bypass", 32'(q_o[1:0]), 32'h1);
    wb(1'b1, 8'h00, 32'h800);
    invert_force_i <= 2'b01;
    pulse(0);
    check("invert force", 32'(q_o[1:0]), 32'h2);
    invert_force_i <= 2'b00;
    init_force_i <= 2'b01;
    tick(5);
    check("sync force waits", 32'(q_o[1:0]), 32'h2);
    pulse(0);
    check("init force", 32'(q_o[1:0]), 32'h1);
    init_force_i <= 2'b00;
    wb(1'b1, 8'h00, 32'h810);
    invert_force_i <= 2'b01;
    tick(5);
    check("async force", 32'(q_o[1:0]), 32'h2);
    invert_force_i <= 2'b00;
    wb(1'b1, 8'h00, 32'h890);
    tick(5);
    check("force inverted", 32'(q_o[1:0]), 32'h1);
    // inverted clock rests high, so the write itself is an edge; invert force is inverted too
    wb(1'b1, 8'h00, 32'h120);
    tick(3);
    check("clock inverted", 32'(q_o[1:0]), 32'h3);
    wb(1'b1, 8'h00, 32'h208);
    hold <= 2'b01;
    byp_i <= 4'h0;
    tick(5);
    check("latch open low", 32'(q_o[0]), 32'h0);
    byp_i <= 4'h1;
    tick(5);
    check("latch open high", 32'(q_o[0]), 32'h1);
    hold <= 2'b00;
    tick(3);
    byp_i <= 4'h0;
    tick(5);
    check("latch closed", 32'(q_o[0]), 32'h1);
    // RAM writes must not depend on clock enable
    ce_i <= 2'b00;
    lut_in_i[7:0] <= 8'h33;
    foreach (rrow[i])
    begin
      lw(0, 32'h0);
      lw(1, 32'h0);
      wb(1'b1, 8'h00, 32'(rrow[i][7:5]));
      wsel_i[0] <= rrow[i][4];
      wd_i[1:0] <= rrow[i][3:2];
      we_i[0] <= 1'b1;
      pulse(0);
      we_i[0] <= 1'b0;
      check("ram read", 32'(lut_o[1:0]), 32'(rrow[i][1:0]));
      wb(1'b0, 8'h08, 32'h0);
      check("ram word 0", r, 32'({rrow[i][0], 3'b000}));
      wb(1'b0, 8'h0c, 32'h0);
      check("ram word 1", r, 32'({rrow[i][1], 3'b000}));
      wsel_i[0] <= 1'b0;
    end
    wb(1'b1, 8'h00, 32'(LCT_SHIFT));
    // shift steps need the slice clock enable
    ce_i <= 2'b11;
    lw(0, 32'h0);
    we_i[0] <= 1'b1;
    for (int k = 3; k >= 0; k--)
    begin
      wd_i[0] <= 1'(4'hd >> k);
      pulse(0);
    end
    we_i[0] <= 1'b0;
    lut_in_i[3:0] <= 4'h2;
    tick(3);
    check("shift tap", 32'(lut_o[0]), 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    check("shift word", r, 32'h0000000d);
    wb(1'b1, 8'h00, 32'h0);
    lw(0, 32'h6666);
    lw(1, 32'h6666);
    for (int k = 0; k < 32; k++)
    begin
      lut_in_i[7:0] <= {2'b00, k[3], k[1], 2'b00, k[2], k[0]};
      carry_in_i[0] <= k[4];
      tick(3);
      s = k[1:0] + k[3:2] + k[4];
      check("adder sum", 32'(sum_o[1:0]), 32'(s[1:0]));
      check("adder carry", 32'(carry_out_o[0]), 32'(s[2]));
    end
    foreach (crow[i])
    begin
      wb(1'b1, 8'h00, 32'(crow[i][41:26]));
      lw(0, 32'(crow[i][25:10]));
      lw(1, 32'(crow[i][25:10]));
      lut_in_i[7:0] <= crow[i][9:2];
      carry_in_i[0] <= crow[i][1];
      tick(3);
      check("carry chain", 32'(carry_out_o[0]), 32'(crow[i][0]));
    end
    // reset in mid-run clears storage and configuration
    wb(1'b1, 8'h00, 32'h4000);
    resetn_i <= 1'b0;
    tick(2);
    check("q in reset", 32'(q_o), 32'h0);
    resetn_i <= 1'b1;
    wb(1'b0, 8'h00, 32'h0);
    check("cfg after reset", r, 32'h0);
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done();
  end
endmodule // configurable_logic_tile_tb_top
